// ==== logic/scth_defs.svh ====
// register offsets, field positions, reset values for the scaler task handler
`ifndef SCTH_DEFS_SVH
`define SCTH_DEFS_SVH

`define SCTH_ADDR_TASK_CTL_A  8'h90
`define SCTH_ADDR_IN_FMT_A    8'h91
`define SCTH_ADDR_TASK_CTL_B  8'hc0
`define SCTH_ADDR_IN_FMT_B    8'hc1

`define SCTH_TASK_CTL_RESET   8'h00
`define SCTH_IN_FMT_RESET     8'h08

`define SCTH_TRIG_MSB         1
`define SCTH_TRIG_LSB         0
`define SCTH_REPEAT_BIT       2
`define SCTH_SKIP_MSB         5
`define SCTH_SKIP_LSB         3
`define SCTH_OFID_SEL_BIT     6
`define SCTH_D7_POL_BIT       7

`define SCTH_SAMPLING_BIT     0
`define SCTH_CHROMA_MSB       2
`define SCTH_CHROMA_LSB       1
`define SCTH_PACING_BIT       3
`define SCTH_SRC_MSB          5
`define SCTH_SRC_LSB          4
`define SCTH_HOLD_FV_BIT      6
`define SCTH_V_POL_BIT        7

`define SCTH_TRIG_IMMEDIATE   2'h0
`define SCTH_TRIG_VSYNC       2'h1
`define SCTH_SRC_DECODER      2'h0
`define SCTH_SRC_XPORT_YUV    2'h1
`define SCTH_SRC_RAW_CVBS     2'h2
`define SCTH_SRC_XPORT_RAW    2'h3

`endif

// ==== logic/scth_pkg.sv ====
// types for the scaler task handler
package scth_pkg;

  typedef enum logic [1:0] {PH_WAIT, PH_SKIP, PH_RUN} scth_phase_t;

  typedef struct packed {
    logic [7:0] taskCtl;
    logic [7:0] inFmt;
  } scth_set_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } scth_word_t;

  typedef struct packed {
    scth_set_t   setA;
    scth_set_t   setB;
    scth_set_t   act;
    logic        actSel;
    scth_phase_t phase;
    logic [2:0]  skipLeft;
    logic        repeatDone;
    logic        taskStart;
    logic        taskFlag;
    logic        taskFlagOut;
    logic        outFieldId;
    logic        savD7;
    logic        savF;
    logic        savV;
    logic        vGate;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        prevVsync;
    scth_word_t  outWord;
    scth_word_t  skid;
    logic        readyDec;
    logic        readyRaw;
    logic        readyXp;
    logic        xpRequest;
  } scth_state_t;

endpackage

// ==== logic/scth_task_handler.sv ====
// scaler task event handler, input source select and two-entry input buffer
`include "scth_defs.svh"

module scth_task_handler (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  input  wire logic        vsync,
  input  wire logic        fieldIdIn,
  input  wire logic        taskDone,
  input  wire logic        procField,
  input  wire logic        procVGate,
  input  wire logic        outLineStart,
  input  wire logic        expansionRequestEnable,
  output logic             taskStart,
  output logic             activeSetB,
  output logic             outFieldId,
  output logic             taskFlag,
  output logic             savD7,
  output logic             savF,
  output logic             savV,
  output logic             verticalGateOutput,
  output logic             inputSamplingScheme,
  output logic      [1:0]  chromaLineRate,
  output logic      [1:0]  inputSourceSelect,
  output logic             continuousStream,
  output logic             expansionRequest,
  input  wire logic        decValid,
  input  wire logic [15:0] decData,
  output logic             decReady,
  input  wire logic        rawValid,
  input  wire logic [15:0] rawData,
  output logic             rawReady,
  input  wire logic        xpValid,
  input  wire logic [15:0] xpData,
  output logic             xpReady,
  output logic             scalerValid,
  output logic      [15:0] scalerData,
  input  wire logic        scalerReady
);

  scth_pkg::scth_state_t st;
  scth_pkg::scth_state_t next_st;

  // trigger decision for the active set
  function automatic logic trigger_hit(input logic [1:0] code, input logic vsEdge,
                                       input logic fid);
    if (code == `SCTH_TRIG_IMMEDIATE)
      trigger_hit = 1'b1;
    else if (code == `SCTH_TRIG_VSYNC)
      trigger_hit = vsEdge;
    else
      trigger_hit = vsEdge && (fid == code[0]);
  endfunction

  // source field of a format byte
  function automatic logic [1:0] source_of(input logic [7:0] fmt);
    source_of = fmt[`SCTH_SRC_MSB:`SCTH_SRC_LSB];
  endfunction

  // vertical flag after the polarity bit of a format byte
  function automatic logic vflag_of(input logic v, input logic [7:0] fmt);
    vflag_of = v ^ fmt[`SCTH_V_POL_BIT];
  endfunction

  // trigger field of a task control byte
  function automatic logic [1:0] trig_of(input logic [7:0] ctl);
    trig_of = ctl[`SCTH_TRIG_MSB:`SCTH_TRIG_LSB];
  endfunction

  // skip count field of a task control byte
  function automatic logic [2:0] skip_of(input logic [7:0] ctl);
    skip_of = ctl[`SCTH_SKIP_MSB:`SCTH_SKIP_LSB];
  endfunction

  // d7 polarity bit of a task control byte
  function automatic logic d7_pol_of(input logic [7:0] ctl);
    d7_pol_of = ctl[`SCTH_D7_POL_BIT];
  endfunction

  // one-hot ready owner per source code: decoder, raw channel, port
  function automatic logic [2:0] owner_of(input logic [1:0] code);
    unique case (code)
      `SCTH_SRC_DECODER:                      owner_of = 3'h4;
      `SCTH_SRC_RAW_CVBS:                     owner_of = 3'h2;
      `SCTH_SRC_XPORT_YUV, `SCTH_SRC_XPORT_RAW: owner_of = 3'h1;
    endcase
  endfunction

  // state after a task activation, task flag toggled
  function automatic scth_pkg::scth_state_t start_task(input scth_pkg::scth_state_t s);
    start_task = s;
    start_task.phase = scth_pkg::PH_RUN;
    start_task.taskStart = 1'b1;
    start_task.taskFlag = !s.taskFlag;
  endfunction

  logic             vsEdge;
  logic             accept;
  logic [15:0]      inData;
  logic             pop;
  logic [1:0]       src;
  logic             nextInReady;
  logic             paced;
  logic [2:0]       owner;

  always_comb
  begin
    next_st = st;
    next_st.taskStart = 1'b0;
    next_st.rdValid = 1'b0;
    next_st.prevVsync = vsync;
    vsEdge = vsync && !st.prevVsync;

    // register writes and reads
    if (regWrite)
    begin
      unique case (regAddr)
        `SCTH_ADDR_TASK_CTL_A: next_st.setA.taskCtl = regWrData;
        `SCTH_ADDR_IN_FMT_A:   next_st.setA.inFmt = regWrData;
        `SCTH_ADDR_TASK_CTL_B: next_st.setB.taskCtl = regWrData;
        `SCTH_ADDR_IN_FMT_B:   next_st.setB.inFmt = regWrData;
        default: ;
      endcase
    end
    if (regRead)
    begin
      next_st.rdValid = 1'b1;
      unique case (regAddr)
        `SCTH_ADDR_TASK_CTL_A: next_st.rdData = st.setA.taskCtl;
        `SCTH_ADDR_IN_FMT_A:   next_st.rdData = st.setA.inFmt;
        `SCTH_ADDR_TASK_CTL_B: next_st.rdData = st.setB.taskCtl;
        `SCTH_ADDR_IN_FMT_B:   next_st.rdData = st.setB.inFmt;
        default:               next_st.rdData = 8'h00;
      endcase
    end

    // active parameters follow the selected set
    next_st.act = st.actSel ? next_st.setB : next_st.setA;

    // event handler sequence
    unique case (st.phase)
      scth_pkg::PH_WAIT:
      begin
        if (trigger_hit(trig_of(st.act.taskCtl), vsEdge, fieldIdIn))
        begin
          next_st.skipLeft = skip_of(st.act.taskCtl);
          if (skip_of(st.act.taskCtl) == 3'h0)
          begin
            next_st = start_task(next_st);
          end
          else
            next_st.phase = scth_pkg::PH_SKIP;
        end
      end
      scth_pkg::PH_SKIP:
      begin
        if (vsEdge)
        begin
          next_st.skipLeft = st.skipLeft - 3'h1;
          if (st.skipLeft == 3'h1)
          begin
            next_st = start_task(next_st);
          end
        end
      end
      scth_pkg::PH_RUN:
      begin
        if (taskDone)
        begin
          if (st.act.taskCtl[`SCTH_REPEAT_BIT] && !st.repeatDone)
          begin
            next_st.repeatDone = 1'b1;
            next_st.taskStart = 1'b1;
          end
          else
          begin
            next_st.repeatDone = 1'b0;
            next_st.actSel = !st.actSel;
            next_st.act = st.actSel ? next_st.setA : next_st.setB;
            next_st.phase = scth_pkg::PH_WAIT;
          end
        end
      end
      // illegal phase code falls back to waiting
      default: next_st.phase = scth_pkg::PH_WAIT;
    endcase

    // field id and SAV/EAV flag bits
    next_st.taskFlagOut = next_st.taskFlag ^ d7_pol_of(next_st.act.taskCtl);
    next_st.savD7 = !d7_pol_of(next_st.act.taskCtl);
    next_st.outFieldId = next_st.act.taskCtl[`SCTH_OFID_SEL_BIT]
                         ? next_st.taskFlag : fieldIdIn;
    if (!next_st.act.inFmt[`SCTH_HOLD_FV_BIT] || outLineStart)
    begin
      next_st.savF = procField;
      next_st.savV = vflag_of(procVGate, next_st.act.inFmt);
    end
    next_st.vGate = vflag_of(procVGate, next_st.act.inFmt);

    // source mux into the two-entry buffer
    accept = 1'b0;
    inData = decData;
    if (st.readyDec && decValid)
    begin
      accept = 1'b1;
      inData = decData;
    end
    else if (st.readyRaw && rawValid)
    begin
      accept = 1'b1;
      inData = rawData;
    end
    else if (st.readyXp && xpValid)
    begin
      accept = 1'b1;
      inData = xpData;
    end
    pop = st.outWord.valid && scalerReady;
    if (!st.outWord.valid || pop)
    begin
      if (st.skid.valid)
      begin
        next_st.outWord = st.skid;
        next_st.skid.valid = accept;
        next_st.skid.data = accept ? inData : st.skid.data;
      end
      else
      begin
        next_st.outWord.valid = accept;
        next_st.outWord.data = accept ? inData : st.outWord.data;
      end
    end
    else if (accept)
    begin
      next_st.skid.valid = 1'b1;
      next_st.skid.data = inData;
    end

    nextInReady = !next_st.skid.valid;
    src = source_of(next_st.act.inFmt);
    owner = owner_of(src);
    next_st.readyDec = nextInReady && owner[2];
    next_st.readyRaw = nextInReady && owner[1];
    next_st.readyXp = nextInReady && owner[0];
    paced = !next_st.act.inFmt[`SCTH_PACING_BIT] && expansionRequestEnable;
    next_st.xpRequest = paced && next_st.readyXp;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.setA <= '{`SCTH_TASK_CTL_RESET, `SCTH_IN_FMT_RESET};
      st.setB <= '{`SCTH_TASK_CTL_RESET, `SCTH_IN_FMT_RESET};
      st.act <= '{`SCTH_TASK_CTL_RESET, `SCTH_IN_FMT_RESET};
      st.phase <= scth_pkg::PH_WAIT;
      st.savD7 <= 1'b1;
    end
    else
      st <= next_st;
  end

  // outputs straight from state
  assign regRdData           = st.rdData;
  assign regRdValid          = st.rdValid;
  assign taskStart           = st.taskStart;
  assign activeSetB          = st.actSel;
  assign outFieldId          = st.outFieldId;
  assign taskFlag            = st.taskFlagOut;
  assign savD7               = st.savD7;
  assign savF                = st.savF;
  assign savV                = st.savV;
  assign verticalGateOutput  = st.vGate;
  assign inputSamplingScheme = st.act.inFmt[`SCTH_SAMPLING_BIT];
  assign chromaLineRate      = st.act.inFmt[`SCTH_CHROMA_MSB:`SCTH_CHROMA_LSB];
  assign inputSourceSelect   = source_of(st.act.inFmt);
  assign continuousStream    = st.act.inFmt[`SCTH_PACING_BIT];
  assign expansionRequest    = st.xpRequest;
  assign decReady            = st.readyDec;
  assign rawReady            = st.readyRaw;
  assign xpReady             = st.readyXp;
  assign scalerValid         = st.outWord.valid;
  assign scalerData          = st.outWord.data;

endmodule // scth_task_handler

// ==== verification/scth_props.sv ====
// concurrent checks on the scaler task handler ports
module scth_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic       regRdValid,
  input wire logic       taskDone,
  input wire logic       taskStart,
  input wire logic       activeSetB,
  input wire logic       taskFlag,
  input wire logic       expansionRequest,
  input wire logic       expansionRequestEnable,
  input wire logic       continuousStream,
  input wire logic [1:0] inputSourceSelect,
  input wire logic       decReady,
  input wire logic       rawReady,
  input wire logic       xpReady
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // recent writes or task ends that may move the flag
  logic [2:0] cause;
  always_ff @(posedge clk)
    cause <= {cause[1:0], regWrite | taskDone};
  property p_swap;
    $changed(activeSetB) |-> $past(taskDone);
  endproperty
  a_swap: assert property (p_swap) else $error("set swap without task end");
  property p_startPulse;
    taskStart |=> !taskStart;
  endproperty
  a_startPulse: assert property (p_startPulse) else $error("start too long");
  property p_flag;
    $changed(taskFlag) |-> taskStart || (|cause);
  endproperty
  a_flag: assert property (p_flag) else $error("flag moved alone");
  property p_pacing;
    expansionRequest |-> !continuousStream && inputSourceSelect[0];
  endproperty
  a_pacing: assert property (p_pacing) else $error("request while continuous");
  property p_reqEn;
    expansionRequest |-> $past(expansionRequestEnable);
  endproperty
  a_reqEn: assert property (p_reqEn) else $error("request while disabled");
  property p_owner;
    decReady || rawReady |-> inputSourceSelect == {rawReady, 1'b0};
  endproperty
  a_owner: assert property (p_owner) else $error("ready of wrong source");
  property p_oneReady;
    $onehot0({decReady, rawReady, xpReady}) && (!xpReady || inputSourceSelect[0]);
  endproperty
  a_oneReady: assert property (p_oneReady) else $error("several readys");
  property p_rdValid;
    regRdValid == $past(regRead);
  endproperty
  a_rdValid: assert property (p_rdValid) else $error("read answer late");
endmodule // scth_props

bind scth_task_handler scth_props scth_props_i (
  .clk(clk), .reset(reset), .regWrite(regWrite), .regRead(regRead),
  .regRdValid(regRdValid), .taskDone(taskDone), .taskStart(taskStart),
  .activeSetB(activeSetB), .taskFlag(taskFlag), .expansionRequest(expansionRequest),
  .expansionRequestEnable(expansionRequestEnable), .continuousStream(continuousStream),
  .inputSourceSelect(inputSourceSelect), .decReady(decReady), .rawReady(rawReady),
  .xpReady(xpReady));

// ==== verification/scth_source_model.sv ====
// video source with valid/ready handshake
module scth_source_model #(
  parameter logic [15:0] KEY = 16'h0000
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        go,
  input  wire logic [16:0] rnd,
  input  wire logic        ready,
  output logic             valid,
  output logic      [15:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  // word held until taken; idle bus toggles
  always @(posedge clk)
    if (reset)
    begin
      valid <= 1'b0;
      data  <= 16'h0000;
    end
    else if (!valid || ready)
    begin
      valid <= go & rnd[16];
      data  <= (go & rnd[16]) ? rnd[15:0] ^ KEY : ~data;
    end
endmodule // scth_source_model

// ==== verification/tb.sv ====
// self-checking bench for the scaler task handler
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        vsync = 1'b0;
  logic        fieldIdIn = 1'b0;
  logic        taskDone = 1'b0;
  logic        procField = 1'b0;
  logic        procVGate = 1'b0;
  logic        outLineStart = 1'b0;
  logic        expansionRequestEnable = 1'b0;
  logic        scalerReady = 1'b0;
  logic        go = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] rnd = 32'h94a1b6a8;
  logic [7:0]  regRdData;
  logic [15:0] decData, rawData, xpData, scalerData;
  logic [1:0]  chromaLineRate, inputSourceSelect;
  logic        regRdValid, taskStart, activeSetB, outFieldId, taskFlag, savD7, savF, savV;
  logic        verticalGateOutput, inputSamplingScheme, continuousStream, expansionRequest;
  logic        decValid, rawValid, xpValid, decReady, rawReady, xpReady, scalerValid;
  logic [15:0] dq[$];
  logic [7:0]  rq[$];
  int          nStart = 0;
  int          cyc = 0;
  int          checks = 0;
  int          miscompares = 0;
  scth_task_handler scth_task_handler_i (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
    .vsync(vsync), .fieldIdIn(fieldIdIn), .taskDone(taskDone), .procField(procField),
    .procVGate(procVGate), .outLineStart(outLineStart),
    .expansionRequestEnable(expansionRequestEnable), .taskStart(taskStart),
    .activeSetB(activeSetB), .outFieldId(outFieldId), .taskFlag(taskFlag), .savD7(savD7),
    .savF(savF), .savV(savV), .verticalGateOutput(verticalGateOutput),
    .inputSamplingScheme(inputSamplingScheme), .chromaLineRate(chromaLineRate),
    .inputSourceSelect(inputSourceSelect), .continuousStream(continuousStream),
    .expansionRequest(expansionRequest), .decValid(decValid), .decData(decData),
    .decReady(decReady), .rawValid(rawValid), .rawData(rawData), .rawReady(rawReady),
    .xpValid(xpValid), .xpData(xpData), .xpReady(xpReady), .scalerValid(scalerValid),
    .scalerData(scalerData), .scalerReady(scalerReady));
  scth_source_model #(.KEY(16'h0000)) dec_i (.clk(clk), .reset(reset), .go(go),
    .rnd(rnd[16:0]), .ready(decReady), .valid(decValid), .data(decData));
  scth_source_model #(.KEY(16'h5a5a)) raw_i (.clk(clk), .reset(reset), .go(go),
    .rnd(rnd[16:0]), .ready(rawReady), .valid(rawValid), .data(rawData));
  scth_source_model #(.KEY(16'ha5c3)) xp_i (.clk(clk), .reset(reset), .go(go),
    .rnd(rnd[16:0]), .ready(xpReady), .valid(xpValid), .data(xpData));
  always #5 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  task automatic vs(input logic fid);
    @(posedge clk);
    fieldIdIn <= fid;
    vsync <= 1'b1;
    repeat (3) @(posedge clk);
    vsync <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic done();
    @(posedge clk);
    taskDone <= 1'b1;
    @(posedge clk);
    taskDone <= 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // cycle ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
  // notes of accepted words, oldest first
  always @(posedge clk)
  begin
    if (decValid && decReady)
      dq.push_back(decData);
    if (rawValid && rawReady)
      dq.push_back(rawData);
    if (xpValid && xpReady)
      dq.push_back(xpData);
    rnd <= xs(rnd);
    scalerReady <= rnd[20] & ~stall;
  end
  // output watcher against the oldest note
  always @(posedge clk)
  begin
    if (taskStart)
      nStart++;
    if (scalerValid && scalerReady)
      cmp(scalerData, dq.pop_front());
    if (regRdValid)
      cmp(16'(regRdData), 16'(rq.pop_front()));
  end
  initial
  begin
    logic [7:0] v;
    logic [1:0] sv;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(negedge clk);
    cmp(16'(nStart), 16'h1);
    cmp(16'(savD7), 16'h1);
    cmp(16'(taskFlag), 16'h1);
    rd(8'h90, 8'h00);
    rd(8'h91, 8'h08);
    rd(8'hc0, 8'h00);
    rd(8'hc1, 8'h08);
    wr(8'h5a, 8'hff);
    rd(8'h5a, 8'h00);
    v = rnd[7:0];
    wr(8'hc1, v);
    rd(8'hc1, v);
    wr(8'hc0, 8'h15);
    done();
    cmp(16'(activeSetB), 16'h1);
    vs(1'b0);
    vs(1'b0);
    cmp(16'(nStart), 16'h1);
    vs(1'b1);
    cmp(16'(nStart), 16'h2);
    cmp(16'(outFieldId), 16'h1);
    done();
    cmp(16'(nStart), 16'h3);
    cmp(16'(activeSetB), 16'h1);
    wr(8'h90, 8'hc3);
    wr(8'hc0, 8'h02);
    done();
    cmp(16'(savD7), 16'h0);
    vs(1'b0);
    cmp(16'(nStart), 16'h3);
    vs(1'b1);
    vs(1'b0);
    cmp(16'(nStart), 16'h4);
    cmp(16'(outFieldId), 16'h1);
    done();
    vs(1'b1);
    cmp(16'(nStart), 16'h4);
    vs(1'b0);
    cmp(16'(nStart), 16'h5);
    @(posedge clk);
    expansionRequestEnable <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      sv = 2'(s);
      procVGate <= sv[0];
      wr(8'hc1, {2'h2, sv, ~sv[0], sv, sv[0]});
      repeat (2) @(negedge clk);
      cmp(16'(inputSourceSelect), 16'(sv));
      cmp(16'(chromaLineRate), 16'(sv));
      cmp(16'(inputSamplingScheme), 16'(sv[0]));
      cmp(16'(continuousStream), 16'(!sv[0]));
      cmp(16'(expansionRequest), 16'(sv[0]));
      cmp(16'(verticalGateOutput), 16'(!sv[0]));
      cmp(16'(savV), 16'(!sv[0]));
      @(posedge clk);
      stall <= 1'b1;
      go <= 1'b1;
      repeat (20) @(negedge clk);
      cmp(16'({decReady, rawReady, xpReady}), 16'h0);
      @(posedge clk);
      stall <= 1'b0;
      repeat (60) @(posedge clk);
      go <= 1'b0;
      for (int k = 0; k < 200 && dq.size() > 0; k++)
        @(posedge clk);
      cmp(16'(dq.size()), 16'h0);
    end
    wr(8'hc1, 8'h48);
    @(posedge clk);
    procField <= 1'b1;
    repeat (3) @(negedge clk);
    cmp(16'(savF), 16'h0);
    @(posedge clk);
    outLineStart <= 1'b1;
    @(posedge clk);
    outLineStart <= 1'b0;
    repeat (2) @(negedge clk);
    cmp(16'(savF), 16'h1);
    cmp(16'(rq.size()), 16'h0);
    end_sim();
  end
endmodule // tb
